// [hw/rte_regs.vh]
// constants for the error, trigger and dropped-request status block
`ifndef RTE_REGS_VH
`define RTE_REGS_VH

// command characters seen on the data write port, and the line feed answer
`define RTE_CHR_LF      8'h0A
`define RTE_CHR_ERR     8'h45
`define RTE_CHR_TRIG    8'h54
`define RTE_CHR_DROP    8'h57
`define RTE_CHR_HALT    8'h41
`define RTE_CHR_REINIT  8'h42

// fault_flags field positions
`define RTE_ERR_MISSED  0
`define RTE_ERR_BAD     1
`define RTE_ERR_ASSIGN  2
`define RTE_ERR_BUSY    3
`define RTE_ERR_RTLOST  4
`define RTE_ERR_CLKHW   5
`define RTE_ERR_MEMLO   6
`define RTE_ERR_MEMHI   7
`define RTE_ERR_SW_MASK 8'h0F

// reset values
`define RTE_ERR_RST     8'h00
`define RTE_CODE_RST    4'h0

// interface_control_byte enable bit
`define RTE_CTRL_IEN    7

// status byte field positions
`define RTE_ST_ERR      0
`define RTE_ST_IFLAG    1
`define RTE_ST_ID       5
`define RTE_ST_ISTAT    7

// timing
`define RTE_CLK_HZ        20000000
`define RTE_SELF_TEST_MS  10000
`define RTE_SELF_TEST_CYC (`RTE_SELF_TEST_MS * (`RTE_CLK_HZ / 1000))

`endif

// [hw/rte_code_latch.v]
// latest-wins port code register, cleared when requested
`include "rte_regs.vh"

module rte_code_latch (
  input  wire       core_clk_i,
  input  wire       srst_i,
  input  wire       clr_i,
  input  wire       load_i,
  input  wire [3:0] ports_i,
  output wire [7:0] code_o
);

  reg [3:0] code_reg;
  reg [3:0] code_next;

  always @* begin
    code_next = code_reg;
    if (clr_i) begin
      code_next = `RTE_CODE_RST;
    end
    // set beats clear; newest event replaces the old one
    if (load_i) begin
      code_next = ports_i;
    end
  end

  always @(posedge core_clk_i) begin
    if (srst_i) begin
      code_reg <= `RTE_CODE_RST;
    end else begin
      code_reg <= code_next;
    end
  end

  assign code_o = {4'h0, code_reg};

endmodule

// [hw/rte_self_test.v]
// power-up / host-reset self test sequencer for the hardware fault bits
`include "rte_regs.vh"

module rte_self_test #(
  parameter [31:0] TEST_CYCLES = `RTE_SELF_TEST_CYC
) (
  input  wire       core_clk_i,
  input  wire       srst_i,
  input  wire       start_i,
  input  wire       clk_hw_fault_i,
  input  wire       mem_lo_fault_i,
  input  wire       mem_hi_fault_i,
  input  wire       rt_lost_i,
  output reg        busy_o,
  output reg        done_o,
  output reg  [3:0] fault_o
);

  reg [31:0] cnt_reg;
  reg [3:0]  seen_reg;

  // faults are gathered over the whole window, not sampled once
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      busy_o   <= 1'b1;
      done_o   <= 1'b0;
      fault_o  <= 4'h0;
      cnt_reg  <= 32'h0000_0000;
      seen_reg <= 4'h0;
    end else if (start_i) begin
      busy_o   <= 1'b1;
      done_o   <= 1'b0;
      cnt_reg  <= 32'h0000_0000;
      seen_reg <= 4'h0;
    end else if (busy_o) begin
      seen_reg <= seen_reg |
                  {mem_hi_fault_i, mem_lo_fault_i, clk_hw_fault_i, rt_lost_i};
      if (cnt_reg >= TEST_CYCLES - 32'h0000_0001) begin
        busy_o  <= 1'b0;
        done_o  <= 1'b1;
        fault_o <= seen_reg |
                   {mem_hi_fault_i, mem_lo_fault_i, clk_hw_fault_i, rt_lost_i};
      end else begin
        cnt_reg <= cnt_reg + 32'h0000_0001;
      end
    end else begin
      done_o <= 1'b0;
    end
  end

endmodule

// [hw/rte_error_status.v]
// error, trigger and dropped-request status block with host byte port
`include "rte_regs.vh"

module rte_error_status #(
  parameter [31:0] SELF_TEST_CYCLES = `RTE_SELF_TEST_CYC
) (
  input  wire       core_clk_i,
  input  wire       srst_i,
  input  wire       host_reset_i,
  input  wire       data_wr_i,
  input  wire [7:0] data_wdata_i,
  input  wire       data_rd_i,
  input  wire       ctrl_wr_i,
  input  wire [7:0] ctrl_wdata_i,
  input  wire [3:0] unit_irq_req_i,
  input  wire [3:0] unit_pulse_i,
  input  wire       bad_instr_i,
  input  wire       assign_conflict_i,
  input  wire       unit_active_i,
  input  wire       rt_lost_i,
  input  wire       clk_hw_fault_i,
  input  wire       mem_lo_fault_i,
  input  wire       mem_hi_fault_i,
  output reg  [7:0] rd_data_o,
  output reg        rd_valid_o,
  output reg  [7:0] status_o,
  output reg        irq_o,
  output reg        rt_eights_o,
  output reg        busy_o
);

  // command decode shared by every command check
  function is_chr;
    input [7:0] byte_in;
    input [7:0] chr;
    begin
      is_chr = (byte_in == chr);
    end
  endfunction

  // status byte layout, shared by the reset value and every update
  function [7:0] status_byte;
    input any_err;
    input int_flag;
    input int_stat;
    begin
      status_byte                = 8'h00;
      status_byte[`RTE_ST_ERR]   = any_err;
      status_byte[`RTE_ST_IFLAG] = int_flag;
      status_byte[`RTE_ST_ID]    = 1'b1;
      status_byte[`RTE_ST_ISTAT] = int_stat;
    end
  endfunction

  reg  [7:0] err_reg;
  reg  [7:0] err_next;
  reg        istat_reg;
  reg        istat_next;
  reg        iflag_reg;
  reg        iflag_next;
  reg  [7:0] obuf_reg;
  reg  [7:0] obuf_next;
  reg        obuf_full_reg;
  reg        obuf_full_next;

  wire       st_busy;
  wire       st_done;
  wire [3:0] st_fault;
  wire [7:0] trig_code;
  wire [7:0] drop_code;

  // host writes are ignored while the self test owns the block
  wire       cmd_ok   = data_wr_i & ~st_busy;
  wire       cmd_err  = cmd_ok & is_chr(data_wdata_i, `RTE_CHR_ERR);
  wire       cmd_trig = cmd_ok & is_chr(data_wdata_i, `RTE_CHR_TRIG);
  wire       cmd_drop = cmd_ok & is_chr(data_wdata_i, `RTE_CHR_DROP);
  wire       cmd_halt = cmd_ok & is_chr(data_wdata_i, `RTE_CHR_HALT);
  wire       cmd_reinit = cmd_ok & is_chr(data_wdata_i, `RTE_CHR_REINIT);

  // unit interrupt requests against the two enable bits
  wire       any_req  = |unit_irq_req_i;
  wire       issue    = any_req & istat_reg & ~st_busy;
  // flag low means not enabled since the last halt, reinit or reset: no missed error at all
  wire       missed   = any_req & ~istat_reg & iflag_reg & ~st_busy;

  // per-port split of each request into issued, dropped or neither
  wire [3:0] req_issued;
  wire [3:0] req_missed;
  genvar     gp;
  generate
    for (gp = 0; gp < 4; gp = gp + 1) begin : g_port
      assign req_issued[gp] = unit_irq_req_i[gp] & issue;
      assign req_missed[gp] = unit_irq_req_i[gp] & missed;
    end
  endgenerate

  wire [3:0] trig_ports = req_issued | unit_pulse_i;
  wire       trig_load  = |trig_ports;
  wire       code_clr   = cmd_reinit | host_reset_i;

  rte_self_test #(
    .TEST_CYCLES (SELF_TEST_CYCLES)
  ) u_self_test (
    .core_clk_i     (core_clk_i),
    .srst_i         (srst_i),
    .start_i        (host_reset_i),
    .clk_hw_fault_i (clk_hw_fault_i),
    .mem_lo_fault_i (mem_lo_fault_i),
    .mem_hi_fault_i (mem_hi_fault_i),
    .rt_lost_i      (rt_lost_i),
    .busy_o         (st_busy),
    .done_o         (st_done),
    .fault_o        (st_fault)
  );

  rte_code_latch u_trig_latch (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .clr_i      (cmd_trig | code_clr),
    .load_i     (trig_load),
    .ports_i    (trig_ports),
    .code_o     (trig_code)
  );

  rte_code_latch u_drop_latch (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .clr_i      (cmd_drop | code_clr),
    .load_i     (missed),
    .ports_i    (req_missed),
    .code_o     (drop_code)
  );

  // fault_flags: clears first, then sets so an event never gets lost
  always @* begin
    err_next = err_reg;
    if (cmd_err | cmd_reinit) begin
      err_next = err_reg & ~`RTE_ERR_SW_MASK;
    end
    if (st_done) begin
      err_next[7:4] = st_fault;
    end
    if (missed) begin
      err_next[`RTE_ERR_MISSED] = 1'b1;
    end
    if (bad_instr_i) begin
      err_next[`RTE_ERR_BAD] = 1'b1;
    end
    if (assign_conflict_i) begin
      err_next[`RTE_ERR_ASSIGN] = 1'b1;
    end
    if (unit_active_i) begin
      err_next[`RTE_ERR_BUSY] = 1'b1;
    end
    if (rt_lost_i) begin
      err_next[`RTE_ERR_RTLOST] = 1'b1;
    end
  end

  // interrupt flag (intent) and interrupt status (armed)
  always @* begin
    istat_next = istat_reg;
    iflag_next = iflag_reg;
    if (issue) begin
      istat_next = 1'b0;
    end
    if (ctrl_wr_i) begin
      // host write wins over the automatic drop in the same cycle
      istat_next = ctrl_wdata_i[`RTE_CTRL_IEN];
      if (ctrl_wdata_i[`RTE_CTRL_IEN]) begin
        iflag_next = 1'b1;
      end
    end
    if (cmd_halt | cmd_reinit | host_reset_i | st_busy) begin
      istat_next = 1'b0;
      iflag_next = 1'b0;
    end
  end

  // single output buffer: a read empties it, a later output overwrites it
  always @* begin
    obuf_next      = obuf_reg;
    obuf_full_next = obuf_full_reg;
    if (data_rd_i) begin
      obuf_full_next = 1'b0;
    end
    if (cmd_err) begin
      obuf_next      = err_reg;
      obuf_full_next = 1'b1;
    end else if (cmd_trig) begin
      obuf_next      = trig_code;
      obuf_full_next = 1'b1;
    end else if (cmd_drop) begin
      obuf_next      = drop_code;
      obuf_full_next = 1'b1;
    end else if (cmd_reinit | st_done) begin
      obuf_next      = `RTE_CHR_LF;
      obuf_full_next = 1'b1;
    end
  end

  always @(posedge core_clk_i) begin
    if (srst_i) begin
      err_reg       <= `RTE_ERR_RST;
      istat_reg     <= 1'b0;
      iflag_reg     <= 1'b0;
      obuf_reg      <= `RTE_CHR_LF;
      obuf_full_reg <= 1'b0;
    end else begin
      err_reg       <= err_next;
      istat_reg     <= istat_next;
      iflag_reg     <= iflag_next;
      obuf_reg      <= obuf_next;
      obuf_full_reg <= obuf_full_next;
    end
  end

  // host-facing outputs, all registered
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      rd_data_o   <= `RTE_CHR_LF;
      rd_valid_o  <= 1'b0;
      status_o    <= status_byte(1'b0, 1'b0, 1'b0);
      irq_o       <= 1'b0;
      rt_eights_o <= 1'b0;
      busy_o      <= 1'b1;
    end else begin
      rd_valid_o <= data_rd_i;
      if (data_rd_i) begin
        // empty buffer answers line feed and raises no error
        rd_data_o <= obuf_full_reg ? obuf_reg : `RTE_CHR_LF;
      end
      irq_o       <= issue;
      rt_eights_o <= err_next[`RTE_ERR_RTLOST];
      busy_o      <= st_busy;
      // built from next values so the byte matches the registers it reports
      status_o    <= status_byte(|err_next, iflag_next, istat_next);
    end
  end

endmodule

// [verification/rte_error_status_props.sv]
// assertions on the status block ports
module rte_props (
  input wire       core_clk_i,
  input wire       srst_i,
  input wire       data_rd_i,
  input wire       ctrl_wr_i,
  input wire [7:0] ctrl_wdata_i,
  input wire [3:0] unit_irq_req_i,
  input wire       rt_lost_i,
  input wire       rd_valid_o,
  input wire [7:0] status_o,
  input wire       irq_o,
  input wire       rt_eights_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (srst_i);
  sequence rd_req;
    data_rd_i;
  endsequence
  sequence rd_ans;
    ##1 rd_valid_o;
  endsequence
  rd_answer_a: assert property (rd_req |-> rd_ans)
    else $error("read not answered");
  rd_single_a: assert property (!data_rd_i |=> !rd_valid_o)
    else $error("read answer without read");
  irq_cause_a: assert property (irq_o |-> $past(|unit_irq_req_i && status_o[7]))
    else $error("interrupt while disabled");
  irq_drop_a: assert property (|unit_irq_req_i && status_o[7] && !ctrl_wr_i
    |=> irq_o && !status_o[7]) else $error("enable not dropped on interrupt");
  never_en_a: assert property (|unit_irq_req_i && !status_o[1] |=> !irq_o)
    else $error("interrupt never enabled");
  ctrl_on_a: assert property (ctrl_wr_i && ctrl_wdata_i[7] |=> status_o[7] && status_o[1])
    else $error("enable write ignored");
  ctrl_off_a: assert property (ctrl_wr_i && !ctrl_wdata_i[7] |=> !status_o[7])
    else $error("disable write ignored");
  rt_eights_a: assert property (rt_lost_i |=> rt_eights_o)
    else $error("lost time not flagged");
endmodule

bind rte_error_status rte_props u_props (.core_clk_i(core_clk_i), .srst_i(srst_i),
  .data_rd_i(data_rd_i), .ctrl_wr_i(ctrl_wr_i), .ctrl_wdata_i(ctrl_wdata_i),
  .unit_irq_req_i(unit_irq_req_i), .rt_lost_i(rt_lost_i), .rd_valid_o(rd_valid_o),
  .status_o(status_o), .irq_o(irq_o), .rt_eights_o(rt_eights_o));

// [verification/rte_host.sv]
// host model: command, control and read strobes
module rte_host (
  input  wire        core_clk_i,
  output logic       data_wr_o,
  output logic [7:0] data_wdata_o,
  output logic       data_rd_o,
  output logic       ctrl_wr_o,
  output logic [7:0] ctrl_wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {data_wr_o, data_rd_o, ctrl_wr_o, data_wdata_o, ctrl_wdata_o} = 19'h0_0000;
  // sel high writes interface_control_byte, else a command char
  task automatic put(input logic sel, input logic [7:0] c);
    @(negedge core_clk_i);
    {ctrl_wr_o, data_wr_o} = sel ? 2'b10 : 2'b01;
    {ctrl_wdata_o, data_wdata_o} = {c, c};
    @(negedge core_clk_i);
    {ctrl_wr_o, data_wr_o} = 2'b00;
    // released lines show the inverse, not a stale value
    {ctrl_wdata_o, data_wdata_o} = ~{c, c};
  endtask
  task automatic get();
    @(negedge core_clk_i);
    data_rd_o = 1'b1;
    @(negedge core_clk_i);
    data_rd_o = 1'b0;
  endtask
endmodule

// [verification/tb.sv]
// self-checking bench for the status block
`include "rte_regs.vh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, a, b); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic [11:0] ev_v = 12'h000;
  logic [2:0]  hw_f = 3'b101;
  logic        host_rst = 1'b0;
  wire         data_wr_i, data_rd_i, ctrl_wr_i, rd_valid_o, irq_o, rt_eights_o, busy_o;
  wire  [7:0]  data_wdata_i, ctrl_wdata_i, rd_data_o, status_o;
  logic [7:0]  exp_q[$];
  logic [7:0]  e;
  logic [3:0]  r1, r2, r3;
  int          n_errors = 0, checked = 0, n_irq = 0, t = 0, i;
  initial forever #25 core_clk_i = ~core_clk_i;
  rte_error_status #(.SELF_TEST_CYCLES(32'd8)) u_dut (.core_clk_i(core_clk_i),
    .srst_i(srst_i), .host_reset_i(host_rst), .data_wr_i(data_wr_i),
    .data_wdata_i(data_wdata_i), .data_rd_i(data_rd_i), .ctrl_wr_i(ctrl_wr_i),
    .ctrl_wdata_i(ctrl_wdata_i), .unit_irq_req_i(ev_v[11:8]), .unit_pulse_i(ev_v[7:4]),
    .bad_instr_i(ev_v[3]), .assign_conflict_i(ev_v[2]), .unit_active_i(ev_v[1]),
    .rt_lost_i(ev_v[0]), .clk_hw_fault_i(hw_f[0]), .mem_lo_fault_i(hw_f[1]),
    .mem_hi_fault_i(hw_f[2]), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
    .status_o(status_o), .irq_o(irq_o), .rt_eights_o(rt_eights_o), .busy_o(busy_o));
  rte_host u_host (.core_clk_i(core_clk_i), .data_wr_o(data_wr_i),
    .data_wdata_o(data_wdata_i), .data_rd_o(data_rd_i), .ctrl_wr_o(ctrl_wr_i),
    .ctrl_wdata_o(ctrl_wdata_i));
  // an empty queue pops unknown, so an unexpected answer mismatches
  always @(negedge core_clk_i) begin
    if (irq_o === 1'b1) n_irq++;
    if (rd_valid_o === 1'b1) begin
      e = exp_q.pop_front();
      `CHK(rd_data_o, e)
    end
  end
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic ask(input logic [7:0] c, input logic [7:0] x);
    exp_q.push_back(x);
    u_host.put(1'b0, c);
    u_host.get();
  endtask
  // irq, pulse, bad, conflict, active, lost
  task automatic ev(input logic [11:0] v);
    @(negedge core_clk_i);
    ev_v = v;
    @(negedge core_clk_i);
    ev_v = 12'h000;
  endtask
  task automatic fin();
    repeat (4) @(negedge core_clk_i);
    t++;
    $display("test %0d done", t);
  endtask
  // bounded wait for the self test to finish
  task automatic wait_idle();
    for (i = 0; i < 100 && busy_o !== 1'b0; i++) @(negedge core_clk_i);
    if (busy_o !== 1'b0) begin
      n_errors++;
      print_verdict();
    end
  endtask
  initial begin
    #(50 * 20000);
    n_errors++;
    print_verdict();
  end
  initial begin
    r1 = 4'($urandom(32'hed12e9a4));
    repeat (6) @(negedge core_clk_i);
    srst_i = 1'b0;
    wait_idle();
    hw_f = 3'b000;
    repeat (2) begin
      exp_q.push_back(`RTE_CHR_LF);
      u_host.get();
    end
    fin();
    ev(12'h00E);
    ask(`RTE_CHR_ERR, 8'hAE);
    ask(`RTE_CHR_ERR, 8'hA0);
    fin();
    r1 = 4'($urandom_range(15, 1));
    r2 = 4'($urandom_range(15, 1));
    r3 = 4'($urandom_range(15, 1));
    ev({r1, 8'h00});
    ask(`RTE_CHR_DROP, 8'h00);
    ask(`RTE_CHR_ERR, 8'hA0);
    fin();
    u_host.put(1'b1, 8'h80);
    ev({r1, 8'h00});
    ev({r2, 8'h00});
    ev({r3, 8'h00});
    ask(`RTE_CHR_TRIG, {4'h0, r1});
    ask(`RTE_CHR_DROP, {4'h0, r3});
    ask(`RTE_CHR_ERR, 8'hA1);
    ask(`RTE_CHR_TRIG, 8'h00);
    ask(`RTE_CHR_DROP, 8'h00);
    `CHK(n_irq, 1)
    u_host.put(1'b1, 8'h80);
    ev({r2, 8'h00});
    fin();
    `CHK(n_irq, 2)
    ev({4'h0, r3, 4'h0});
    ask(`RTE_CHR_TRIG, {4'h0, r3});
    ev(12'h050);
    ask(`RTE_CHR_TRIG, 8'h05);
    u_host.put(1'b0, `RTE_CHR_DROP);
    ask(`RTE_CHR_ERR, 8'hA0);
    fin();
    ev(12'h001);
    `CHK(rt_eights_o, 1'b1)
    ask(`RTE_CHR_ERR, 8'hB0);
    fin();
    ev(12'h002);
    u_host.put(1'b1, 8'h80);
    `CHK(status_o, 8'hA3)
    u_host.put(1'b1, 8'h00);
    `CHK(status_o, 8'h23)
    ev({r2, 8'h00});
    u_host.put(1'b0, `RTE_CHR_HALT);
    `CHK(status_o, 8'h21)
    ev({r1, 8'h00});
    ask(`RTE_CHR_DROP, {4'h0, r2});
    `CHK(n_irq, 2)
    u_host.put(1'b0, `RTE_CHR_REINIT);
    exp_q.push_back(`RTE_CHR_LF);
    u_host.get();
    ask(`RTE_CHR_ERR, 8'hB0);
    fin();
    hw_f = 3'b010;
    @(negedge core_clk_i);
    host_rst = 1'b1;
    @(negedge core_clk_i);
    host_rst = 1'b0;
    repeat (2) @(negedge core_clk_i);
    `CHK(busy_o, 1'b1)
    wait_idle();
    hw_f = 3'b000;
    `CHK(rt_eights_o, 1'b0)
    exp_q.push_back(`RTE_CHR_LF);
    u_host.get();
    ask(`RTE_CHR_ERR, 8'h40);
    fin();
    `CHK(exp_q.size(), 0)
    print_verdict();
  end
endmodule
